// ===== hdl/cvm_mapper.sv
// Channel value mapper: switch and dimming telegrams against a coil and a word register image.
// Summary of operation
// R1: Bit mode copies the switch value onto the coil.
// R2: Inversion makes the coil the complement of the switch value, both ways.
// R3: Bit-in-word mode maps the switch value onto one word bit, optionally inverted.
// R4: Value mode uses a field of given width at given offset from the LSB.
// R5: An ON telegram writes the ON value into the field when enabled.
// R6: An OFF telegram writes the OFF value into the field when enabled.
// R7: Field above threshold triggers its configured send action.
// R8: Field equal to threshold triggers its configured send action.
// R9: Field below threshold triggers its configured send action.
// R10: Each dimming command sets, clears or leaves the coil as configured.
// R11: Each monitored bit state sends its configured dimming command or nothing.
// R12: Bit-in-word dimming applies the per-command actions to the chosen word bit.
// R13: A dim-up command writes its value into the field when enabled.
// R14: A dim-down command writes its value into the field when enabled.
// R15: A field with width plus offset above sixteen disables the channel.
// R16: A value wider than the field is rejected and never written.
// R17: A dim-stop command writes its value into the field when enabled.
// R18: Field and bit writes keep every other bit of the word.
// R19: Field and threshold compare as unsigned numbers of field width.
`timescale 1ns/1ps
module cvm_mapper import cvm_pkg::*; (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received group telegram.
    input wire logic rx_valid,
    input wire logic rx_switch,
    input wire logic [1:0] rx_dim,
    // Telegram to send.
    output logic tx_valid,
    output logic tx_switch,
    output logic [1:0] tx_dim
);
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, tx_valid_ff, tx_switch_ff, eval_ff, rng_ff;
    logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid, nxt_tx_valid, nxt_tx_switch;
    logic nxt_eval, nxt_rng, coil_ff, nxt_coil;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp, tx_dim_ff, nxt_tx_dim;
    logic [31:0] rdata_ff, nxt_rdata, ctrl_ff, nxt_ctrl, act_ff, nxt_act, thr_ff, nxt_thr;
    logic [15:0] word_ff, nxt_word, vala_ff, nxt_vala, valb_ff, nxt_valb, valc_ff, nxt_valc;

    function automatic logic [15:0] fmask(input logic [4:0] cnt, input logic [3:0] off);
        logic [16:0] m;
        m = (17'(1) << cnt) - 17'(1);
        return 16'(m << off);
    endfunction
    function automatic logic [15:0] fext(input logic [15:0] w, input logic [4:0] cnt, input logic [3:0] off);
        return (w & fmask(cnt, off)) >> off;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [1:0] mode;
    logic dir, dpt, inv;
    logic [3:0] pos, off;
    logic [4:0] cnt;
    logic [15:0] msk, fld, thv;
    logic cfg_ok, wr_hs, rd_hs, wr_word, wr_coil;
    assign mode = ctrl_ff[C_MODE +: 2];
    assign dir = ctrl_ff[C_DIR];
    assign dpt = ctrl_ff[C_DPT];
    assign inv = ctrl_ff[C_INV];
    assign pos = ctrl_ff[C_POS +: 4];
    assign cnt = ctrl_ff[C_CNT +: 5];
    assign off = ctrl_ff[C_OFF +: 4];
    assign msk = fmask(cnt, off); // [R4]
    // A zero width or a field past bit 15 leaves the channel idle. [R15]
    assign cfg_ok = (mode != MD_VAL) || (cnt != 5'h0 && ({1'b0, cnt} + {2'h0, off}) <= 6'(WORD_W));
    assign fld = fext(word_ff, cnt, off); // [R19]
    assign thv = thr_ff[15:0] & (msk >> off);
    // The bus write is taken in the cycle that both readies stand high.
    assign wr_hs = awready_ff && wready_ff;
    assign rd_hs = arready_ff;
    assign wr_word = wr_hs && s_axi_awaddr == OFS_WORD;
    assign wr_coil = wr_hs && s_axi_awaddr == OFS_COIL;

    logic tel_ok, bit_wr, bit_v, val_wr, val_fit;
    logic [1:0] bact, snd;
    logic [15:0] val, wbase;
    always_comb begin
        tel_ok = rx_valid && !dir && cfg_ok;
        bact = ACT_NONE;
        case (rx_dim)
            DIM_UP: bact = act_ff[A_UP +: 2];
            DIM_DOWN: bact = act_ff[A_DN +: 2];
            DIM_STOP: bact = act_ff[A_ST +: 2];
            default: bact = ACT_NONE;
        endcase
        bit_wr = dpt ? (bact != ACT_NONE) : 1'b1; // [R10] [R12]
        bit_v = dpt ? (bact == ACT_SET) : (rx_switch ^ inv); // [R1] [R2] [R3]
        val_wr = 1'b0;
        val = 16'h0;
        if (!dpt) begin
            val_wr = rx_switch ? act_ff[A_EN] : act_ff[A_EN + 1]; // [R5] [R6]
            val = rx_switch ? vala_ff : valb_ff;
        end else begin
            case (rx_dim)
                DIM_UP: begin
                    val_wr = act_ff[A_EN]; // [R13]
                    val = vala_ff;
                end
                DIM_DOWN: begin
                    val_wr = act_ff[A_EN + 1]; // [R14]
                    val = valb_ff;
                end
                DIM_STOP: begin
                    val_wr = act_ff[A_EN + 2]; // [R17]
                    val = valc_ff;
                end
                default: begin
                    val_wr = 1'b0;
                    val = 16'h0;
                end
            endcase
        end
        val_fit = (val & ~(msk >> off)) == 16'h0; // [R16]
        snd = SND_NONE;
        if (mode == MD_VAL) begin
            if (fld > thv) begin
                snd = thr_ff[T_HI +: 2]; // [R7]
            end else if (fld == thv) begin
                snd = thr_ff[T_EQ +: 2]; // [R8]
            end else begin
                snd = thr_ff[T_LO +: 2]; // [R9]
            end
        end else begin
            snd = ((mode == MD_BIT) ? coil_ff : word_ff[pos]) ? thr_ff[T_B1 +: 2] : thr_ff[T_B0 +: 2]; // [R11]
        end
        wbase = wr_word ? 16'(merge(32'(word_ff), s_axi_wdata, s_axi_wstrb)) : word_ff;
    end

    // Bus slave, register file and telegram handling.
    always_comb begin
        nxt_awready = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
        nxt_wready = nxt_awready;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_arready = s_axi_arvalid && !arready_ff && !rvalid_ff;
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_act = act_ff;
        nxt_thr = thr_ff;
        nxt_vala = vala_ff;
        nxt_valb = valb_ff;
        nxt_valc = valc_ff;
        nxt_coil = coil_ff;
        nxt_word = wbase;
        nxt_rng = rng_ff;
        nxt_eval = (wr_word || wr_coil) && dir && cfg_ok;
        nxt_tx_valid = 1'b0;
        nxt_tx_switch = tx_switch_ff;
        nxt_tx_dim = tx_dim_ff;
        if (wr_hs) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (s_axi_awaddr)
                OFS_CTRL: nxt_ctrl = merge(ctrl_ff, s_axi_wdata, s_axi_wstrb);
                OFS_WORD: nxt_word = wbase;
                OFS_COIL: nxt_coil = s_axi_wstrb[0] ? s_axi_wdata[0] : coil_ff;
                OFS_VALA: nxt_vala = 16'(merge(32'(vala_ff), s_axi_wdata, s_axi_wstrb));
                OFS_VALB: nxt_valb = 16'(merge(32'(valb_ff), s_axi_wdata, s_axi_wstrb));
                OFS_VALC: nxt_valc = 16'(merge(32'(valc_ff), s_axi_wdata, s_axi_wstrb));
                OFS_ACT: nxt_act = merge(act_ff, s_axi_wdata, s_axi_wstrb);
                OFS_THR: nxt_thr = merge(thr_ff, s_axi_wdata, s_axi_wstrb);
                OFS_STAT: nxt_rng = rng_ff && !(s_axi_wstrb[0] && s_axi_wdata[S_RNG]);
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        // A telegram lands on top of a same-cycle bus write and wins wherever both touch the same bits.
        if (tel_ok) begin
            case (mode)
                MD_BIT: nxt_coil = bit_wr ? bit_v : nxt_coil; // [R1] [R2] [R10]
                MD_BITW: begin
                    if (bit_wr) begin
                        nxt_word[pos] = bit_v; // [R3] [R12] [R18]
                    end
                end
                MD_VAL: begin
                    if (val_wr && val_fit) begin
                        nxt_word = (wbase & ~msk) | ((val << off) & msk); // [R4] [R18]
                    end else if (val_wr) begin
                        nxt_rng = 1'b1; // [R16]
                    end
                end
                default: nxt_coil = nxt_coil;
            endcase
        end
        if (eval_ff) begin
            if (!dpt) begin
                nxt_tx_valid = (mode != MD_VAL) || snd == SND_A || snd == SND_B; // [R7] [R8] [R9]
                nxt_tx_switch = ((mode == MD_BIT) ? coil_ff : word_ff[pos]) ^ inv; // [R2] [R3]
                if (mode == MD_VAL) begin
                    nxt_tx_switch = snd == SND_A;
                end
            end else begin
                nxt_tx_valid = snd != SND_NONE; // [R11]
                nxt_tx_dim = (snd == SND_A) ? DIM_UP : (snd == SND_B) ? DIM_DOWN : DIM_STOP;
            end
        end
        if (rd_hs) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL: nxt_rdata = ctrl_ff;
                OFS_WORD: nxt_rdata = 32'(word_ff);
                OFS_COIL: nxt_rdata = 32'(coil_ff);
                OFS_VALA: nxt_rdata = 32'(vala_ff);
                OFS_VALB: nxt_rdata = 32'(valb_ff);
                OFS_VALC: nxt_rdata = 32'(valc_ff);
                OFS_ACT: nxt_rdata = act_ff;
                OFS_THR: nxt_rdata = thr_ff;
                OFS_STAT: nxt_rdata = 32'({rng_ff, !cfg_ok}); // [R15]
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0;
            ctrl_ff <= CTRL_RST;
            act_ff <= 32'h0;
            thr_ff <= 32'h0;
            vala_ff <= 16'h0;
            valb_ff <= 16'h0;
            valc_ff <= 16'h0;
            coil_ff <= 1'b0;
            word_ff <= 16'h0;
            rng_ff <= 1'b0;
            eval_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_switch_ff <= 1'b0;
            tx_dim_ff <= DIM_STOP;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            act_ff <= nxt_act;
            thr_ff <= nxt_thr;
            vala_ff <= nxt_vala;
            valb_ff <= nxt_valb;
            valc_ff <= nxt_valc;
            coil_ff <= nxt_coil;
            word_ff <= nxt_word;
            rng_ff <= nxt_rng;
            eval_ff <= nxt_eval;
            tx_valid_ff <= nxt_tx_valid;
            tx_switch_ff <= nxt_tx_switch;
            tx_dim_ff <= nxt_tx_dim;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_switch = tx_switch_ff;
    assign tx_dim = tx_dim_ff;

    a_coil_copy: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        tel_ok && !dpt && mode == MD_BIT && !inv |=> coil_ff == $past(rx_switch))
        else $error("coil does not follow switch value");
    a_coil_invert: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        tel_ok && !dpt && mode == MD_BIT && inv |=> coil_ff != $past(rx_switch))
        else $error("inverted coil equals switch value");
    a_word_bit: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        tel_ok && !dpt && mode == MD_BITW |=> word_ff[$past(pos)] == ($past(rx_switch) ^ $past(inv)))
        else $error("word bit does not follow switch value");
    a_on_value: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        tel_ok && !dpt && mode == MD_VAL && rx_switch && act_ff[A_EN] && val_fit
        |=> fext(word_ff, cnt, off) == $past(vala_ff))
        else $error("on value not written into field");
    a_bad_config: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
        rx_valid && !cfg_ok && !wr_hs |=> $stable(word_ff) && $stable(coil_ff))
        else $error("misconfigured channel changed the image");
    a_value_range: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        tel_ok && mode == MD_VAL && val_wr && !val_fit && !wr_word |=> rng_ff && $stable(word_ff))
        else $error("oversized value was not rejected");
    a_keep_bits: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        tel_ok && mode == MD_VAL && !wr_word |=> ((word_ff ^ $past(word_ff)) & ~$past(msk)) == 16'h0)
        else $error("bits outside the field changed");
    a_higher_on: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        eval_ff && !dpt && mode == MD_VAL && fld > thv && thr_ff[T_HI +: 2] == SND_A
        |=> tx_valid && tx_switch ##1 !tx_valid)
        else $error("higher field did not send one on telegram");
    a_dim_bit_one: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        eval_ff && dpt && mode == MD_BIT && coil_ff && thr_ff[T_B1 +: 2] == SND_C
        |=> tx_valid && tx_dim == DIM_STOP)
        else $error("set bit did not send stop command");
endmodule // cvm_mapper

// ===== inc/cvm_pkg.sv
// Package with register map, field layout and codes of the channel value mapper.
package cvm_pkg;
    localparam int WORD_W = 16;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORD = 8'h04;
    localparam logic [7:0] OFS_COIL = 8'h08;
    localparam logic [7:0] OFS_VALA = 8'h0c;
    localparam logic [7:0] OFS_VALB = 8'h10;
    localparam logic [7:0] OFS_VALC = 8'h14;
    localparam logic [7:0] OFS_ACT = 8'h18;
    localparam logic [7:0] OFS_THR = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    // Control register layout.
    localparam int C_MODE = 0;
    localparam int C_DIR = 2;
    localparam int C_DPT = 3;
    localparam int C_INV = 4;
    localparam int C_POS = 8;
    localparam int C_CNT = 12;
    localparam int C_OFF = 20;
    // Write-action register layout.
    localparam int A_EN = 0;
    localparam int A_UP = 4;
    localparam int A_DN = 6;
    localparam int A_ST = 8;
    // Threshold register layout.
    localparam int T_HI = 16;
    localparam int T_EQ = 18;
    localparam int T_LO = 20;
    localparam int T_B1 = 24;
    localparam int T_B0 = 26;
    localparam int S_CFG = 0;
    localparam int S_RNG = 1;
    localparam logic [31:0] CTRL_RST = 32'h0000_1000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] MD_BIT = 2'h0;
    localparam logic [1:0] MD_BITW = 2'h1;
    localparam logic [1:0] MD_VAL = 2'h2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_SET = 2'h1;
    localparam logic [1:0] ACT_CLR = 2'h2;
    localparam logic [1:0] SND_NONE = 2'h0;
    localparam logic [1:0] SND_A = 2'h1;
    localparam logic [1:0] SND_B = 2'h2;
    localparam logic [1:0] SND_C = 2'h3;
    localparam logic [1:0] DIM_UP = 2'h0;
    localparam logic [1:0] DIM_DOWN = 2'h1;
    localparam logic [1:0] DIM_STOP = 2'h2;
endpackage

// ===== bench/cvm_knx_model.sv
// Far-side telegram model: issues received telegrams and logs every telegram sent.
`timescale 1ns/1ps
module cvm_knx_model (
    // Clock.
    input wire logic aclk,
    // Telegram towards the mapper.
    output logic rx_valid,
    output logic rx_switch,
    output logic [1:0] rx_dim,
    // Telegram from the mapper.
    input wire logic tx_valid,
    input wire logic tx_switch,
    input wire logic [1:0] tx_dim
);
    int tx_n = 0;
    logic tx_sw = 1'b0;
    logic [1:0] tx_dm = 2'h0;
    initial begin
        rx_valid = 1'b0;
        rx_switch = 1'b0;
        rx_dim = 2'h3;
    end
    // Data lines flip once the strobe drops, so a stale value can never pass for a fresh one.
    task automatic send(input logic sw, input logic [1:0] dm);
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_switch <= sw;
        rx_dim <= dm;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_switch <= ~sw;
        rx_dim <= ~dm;
    endtask
    always @(posedge aclk) begin
        if (tx_valid === 1'b1) begin
            tx_n <= tx_n + 1;
            tx_sw <= tx_switch;
            tx_dm <= tx_dim;
        end
    end
endmodule // cvm_knx_model

// ===== bench/tb_top.sv
// Self-checking bench for the channel value mapper.
`timescale 1ns/1ps
module tb_top import cvm_pkg::*; ;
    logic aclk;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic rx_valid, rx_switch, tx_valid, tx_switch;
    logic [1:0] rx_dim, tx_dim;
    int failures = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [7:0] tgt;

    cvm_mapper cvm_mapper_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid(rx_valid),
        .rx_switch(rx_switch), .rx_dim(rx_dim), .tx_valid(tx_valid), .tx_switch(tx_switch), .tx_dim(tx_dim));
    cvm_knx_model cvm_knx_model_i (.aclk(aclk), .rx_valid(rx_valid), .rx_switch(rx_switch),
        .rx_dim(rx_dim), .tx_valid(tx_valid), .tx_switch(tx_switch), .tx_dim(tx_dim));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Response ready is held high throughout, so each answer is taken at the edge it shows.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask

    task automatic rdw(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rdw(a);
        check(rd, exp);
    endtask

    // A telegram out is due two edges after the write is taken; three edges leave room for the log.
    task automatic txw(input logic [7:0] a, input logic [31:0] d, input int cnt, input logic dim, input logic [1:0] v);
        int n0;
        n0 = cvm_knx_model_i.tx_n;
        wr(a, d);
        repeat (3) @(posedge aclk);
        check(32'(cvm_knx_model_i.tx_n - n0), 32'(cnt));
        if (cnt > 0) begin
            check(dim ? 32'(cvm_knx_model_i.tx_dm) : 32'(cvm_knx_model_i.tx_sw), 32'(v));
        end
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] md, input logic dir, input logic dpt, input logic inv,
                                        input logic [3:0] pos, input logic [4:0] cnt, input logic [3:0] off);
        return {8'h00, off, 3'h0, cnt, pos, 3'h0, inv, dpt, dir, md};
    endfunction

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(tx_dim, DIM_STOP);
        rchk(OFS_CTRL, CTRL_RST);
        check(rsp, RESP_OKAY);
        rchk(8'h24, 32'h0);
        check(rsp, RESP_SLVERR);
        wr(8'h24, 32'h5);
        check(rsp, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, ctl(MD_BIT, 1'b0, 1'b0, i[1], 4'h0, 5'h1, 4'h0));
            cvm_knx_model_i.send(i[0], DIM_STOP);
            rchk(OFS_COIL, 32'(i[0] ^ i[1]));
        end
        wr(OFS_WORD, 32'ha5a5);
        wr(OFS_CTRL, ctl(MD_BITW, 1'b0, 1'b0, 1'b0, 4'h6, 5'h1, 4'h0));
        cvm_knx_model_i.send(1'b1, DIM_STOP);
        rchk(OFS_WORD, 32'ha5e5);
        wr(OFS_CTRL, ctl(MD_BITW, 1'b0, 1'b0, 1'b1, 4'h6, 5'h1, 4'h0));
        cvm_knx_model_i.send(1'b1, DIM_STOP);
        rchk(OFS_WORD, 32'ha5a5);
        wr(OFS_WORD, 32'hffff);
        wr(OFS_VALA, 32'h9);
        wr(OFS_VALB, 32'h3);
        wr(OFS_ACT, 32'h1);
        wr(OFS_CTRL, ctl(MD_VAL, 1'b0, 1'b0, 1'b0, 4'h0, 5'h4, 4'h6));
        cvm_knx_model_i.send(1'b1, DIM_STOP);
        rchk(OFS_WORD, 32'hfe7f);
        cvm_knx_model_i.send(1'b0, DIM_STOP);
        rchk(OFS_WORD, 32'hfe7f);
        wr(OFS_ACT, 32'h3);
        cvm_knx_model_i.send(1'b0, DIM_STOP);
        rchk(OFS_WORD, 32'hfcff);
        wr(OFS_VALA, 32'h1f);
        cvm_knx_model_i.send(1'b1, DIM_STOP);
        rchk(OFS_WORD, 32'hfcff);
        rchk(OFS_STAT, 32'h2);
        wr(OFS_STAT, 32'h2);
        check(rsp, RESP_OKAY);
        wr(OFS_CTRL, ctl(MD_VAL, 1'b0, 1'b0, 1'b0, 4'h0, 5'ha, 4'h6));
        rchk(OFS_STAT, 32'h0);
        wr(OFS_CTRL, ctl(MD_VAL, 1'b0, 1'b0, 1'b0, 4'h0, 5'hb, 4'h6));
        rchk(OFS_STAT, 32'h1);
        cvm_knx_model_i.send(1'b0, DIM_STOP);
        rchk(OFS_WORD, 32'hfcff);
        wr(OFS_WORD, 32'h0);
        wr(OFS_ACT, 32'h90);
        for (int m = 0; m < 2; m++) begin
            tgt = (m == 0) ? OFS_COIL : OFS_WORD;
            wr(OFS_CTRL, ctl(2'(m), 1'b0, 1'b1, 1'b0, 4'h3, 5'h1, 4'h0));
            cvm_knx_model_i.send(1'b0, DIM_UP);
            rchk(tgt, (m == 0) ? 32'h1 : 32'h8);
            cvm_knx_model_i.send(1'b0, DIM_STOP);
            rchk(tgt, (m == 0) ? 32'h1 : 32'h8);
            cvm_knx_model_i.send(1'b0, DIM_DOWN);
            rchk(tgt, 32'h0);
        end
        wr(OFS_WORD, 32'h1230);
        wr(OFS_VALA, 32'h5);
        wr(OFS_VALB, 32'h6);
        wr(OFS_VALC, 32'h7);
        wr(OFS_ACT, 32'h3);
        wr(OFS_CTRL, ctl(MD_VAL, 1'b0, 1'b1, 1'b0, 4'h0, 5'h4, 4'h0));
        cvm_knx_model_i.send(1'b0, DIM_UP);
        rchk(OFS_WORD, 32'h1235);
        cvm_knx_model_i.send(1'b0, DIM_DOWN);
        rchk(OFS_WORD, 32'h1236);
        cvm_knx_model_i.send(1'b0, DIM_STOP);
        rchk(OFS_WORD, 32'h1236);
        wr(OFS_ACT, 32'h7);
        cvm_knx_model_i.send(1'b0, DIM_STOP);
        rchk(OFS_WORD, 32'h1237);
        wr(OFS_CTRL, ctl(MD_BIT, 1'b1, 1'b0, 1'b1, 4'h0, 5'h1, 4'h0));
        txw(OFS_COIL, 32'h1, 1, 1'b0, 2'h0);
        wr(OFS_THR, 32'h0009_0005);
        wr(OFS_CTRL, ctl(MD_VAL, 1'b1, 1'b0, 1'b0, 4'h0, 5'h4, 4'h4));
        txw(OFS_WORD, 32'hf06f, 1, 1'b0, 2'h1);
        txw(OFS_WORD, 32'h0f5f, 1, 1'b0, 2'h0);
        txw(OFS_WORD, 32'hff4f, 0, 1'b0, 2'h0);
        wr(OFS_THR, 32'h0019_0005);
        txw(OFS_WORD, 32'h004f, 1, 1'b0, 2'h1);
        txw(OFS_WORD, 32'h00f0, 1, 1'b0, 2'h1);
        wr(OFS_THR, 32'h0d00_0000);
        wr(OFS_CTRL, ctl(MD_BIT, 1'b1, 1'b1, 1'b0, 4'h0, 5'h1, 4'h0));
        txw(OFS_COIL, 32'h1, 1, 1'b1, DIM_UP);
        txw(OFS_COIL, 32'h0, 1, 1'b1, DIM_STOP);
        wr(OFS_THR, 32'h0200_0000);
        txw(OFS_COIL, 32'h1, 1, 1'b1, DIM_DOWN);
        txw(OFS_COIL, 32'h0, 0, 1'b1, DIM_DOWN);
        wr(OFS_THR, 32'h0300_0000);
        txw(OFS_COIL, 32'h1, 1, 1'b1, DIM_STOP);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        close_out();
    end
endmodule // tb_top
